/* tsx_core.sv */
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tsx_defines.svh"
// Behaviour
// [R1] Accept 64 input lanes up to 16.384Mb/s, 256 channels per frame.
// [R2] Output lanes run at exactly the input bit rate.
// [R3] Deserialise inputs into data memory, addressed from the frame pulse.
// [R4] Each output lane channel has its own connection entry naming a source.
// [R5] Processor mode sends the entry's low byte every frame.
// [R6] Top two entry bits select the mode; 1-1 floats only that channel.
// [R7] Drive pin low and standby bit low float every output.
// [R8] Top rate uses one clock per bit, lower rates two.
// [R9] Software sets the two-bit rate field; timing follows it.
// [R10] Frame pulse is classified negative-edge or GCI automatically.
// [R11] Negative-edge top rate: launch on falling, sample next rising.
// [R12] Negative-edge lower rates: boundary each second fall, sample rising at 3/4.
// [R13] GCI top rate: launch on rising, sample next falling.
// [R14] GCI lower rates: boundary each second rise, sample falling at 3/4.
// [R15] Each input lane delays by 0 to 7.5 clocks in half steps.
// [R16] Start bit low a frame then high: done two frames later, offset bits 0-11.
// [R17] Software clears the start bit before another measurement.
// [R18] Measure falling edges in negative-edge format, rising in GCI.
// [R19] Armed fill writes pattern to entry bits 15:14, zeros below, within two frames.
// [R20] Fill completion clears start, pattern and arm bits.
// [R21] Variable delay: outputs n..n+2 next frame, n+3 on same frame.
// [R22] Constant delay: frame n data leaves in frame n+2.
// [R23] Selector 1-0 is processor mode; bits 13-0 address the source.
// [R24] Drive pin high enables all drivers, channel float still applies.
// [R25] Writes of the current frame never touch buffers being read; variable-delay channels past source+2 read the buffer being written.
module tsx_core
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial timing inputs.
	input wire logic master_clk,
	input wire logic frame_sync_pulse,
	input wire logic frame_eval_in,
	input wire logic master_output_drive,
	// Serial lanes.
	input wire logic [63:0] rx_lane,
	output logic [63:0] tx_lane,
	output logic [63:0] tx_oe_n
);
	localparam int NL = `TSX_LANES;
	localparam int NC = `TSX_CHANS;

	// Channel count mask for the selected rate.
	function automatic logic [7:0] ch_mask(input logic [1:0] r);
		ch_mask = 8'hff >> (2'h3 - r);
	endfunction

	// Buffer index k frames before b, modulo three.
	function automatic logic [1:0] buf_back(input logic [1:0] b, input logic [1:0] k);
		logic [2:0] s;
		s = {1'b0, b} + 3'h3 - {1'b0, k};
		buf_back = 2'((s >= 3'h3) ? s - 3'h3 : s);
	endfunction

	logic [8:0] ctrl;
	logic [3:0] lane_ofs [0:NL-1];
	logic [15:0] cm [0:NL-1][0:NC-1];
	logic [7:0] dm [0:2][0:NL-1][0:NC-1];
	logic d_wr, d_rd;
	logic [17:0] d_addr;
	logic mclk_q, fp_q, fp_armed, gci, phase;
	logic [3:0] fp_run;
	logic [10:0] bit_cnt;
	logic [14:0] samp_hist, fs_hist;
	logic [1:0] wbuf;
	logic fill_on;
	logic [7:0] fill_idx;
	tsx_pkg::tsx_eval_t ev_state;
	logic [1:0] ev_frames;
	logic [11:0] meas;
	logic align_done, sfe_q, low_frame, fp_h, fe_h;
	logic [1:0] lane_mode [0:NL-1];
	logic [1:0] lane_rb [0:NL-1];
	logic [7:0] lane_next [0:NL-1];
	logic [7:0] lane_sr [0:NL-1];
	logic rx_wr [0:NL-1];
	logic [7:0] rx_byte [0:NL-1];
	logic [7:0] rx_wch [0:NL-1];
	logic [1:0] rx_wbuf [0:NL-1];

	// Control fields.
	wire [1:0] rate = ctrl[`TSX_RATE_LSB +: 2]; // R9
	wire top_rate = rate == tsx_pkg::TSX_RATE_16M; // R8
	wire [7:0] mask = ch_mask(rate); // R1
	wire master_en = master_output_drive | ctrl[`TSX_OSB_BIT]; // R7 R24

	// Master clock edges and their roles in each framing format.
	wire m_rise = master_clk & ~mclk_q;
	wire m_fall = ~master_clk & mclk_q;
	wire m_edge = m_rise | m_fall;
	wire launch_ev = gci ? m_rise : m_fall; // R11 R13
	wire opp_ev = gci ? m_fall : m_rise; // R11 R13
	wire boundary = launch_ev & (top_rate | ~phase); // R12 R14
	wire samp_ev = opp_ev & (top_rate | ~phase); // R12 R14

	// Frame pulse: the short level run is the pulse, its level names the format.
	wire fp_chg = m_edge & (frame_sync_pulse != fp_q);
	wire pulse_end = fp_chg & (fp_run < `TSX_PULSE_MAX); // R10
	wire frame_start = launch_ev & (fp_armed | pulse_end); // R3
	wire out_tick = boundary | frame_start; // R2
	wire [10:0] cur_bit = frame_start ? 11'h000 : bit_cnt;
	wire [7:0] out_ch = cur_bit[10:3] & mask;
	wire out_load = out_tick & (cur_bit[2:0] == 3'h0);
	wire [1:0] next_wbuf = frame_start ? buf_back(wbuf, 2'h2) : wbuf; // R25

	// Bus decode.
	wire take = hsel & hready & htrans[1] & (hsize == 3'h2);
	wire sel_cm = d_addr[17:16] == `TSX_CM_PAGE;
	wire sel_ctrl = d_addr == `TSX_CTRL_ADDR;
	wire sel_align = d_addr == `TSX_ALIGN_ADDR;
	wire sel_ofs = d_addr[17:8] == `TSX_OFS_PAGE;
	wire [15:0] cm_rd = cm[d_addr[15:10]][d_addr[9:2]];
	wire [31:0] rd_val = sel_cm ? {16'h0000, cm_rd} :
		sel_ctrl ? {23'h000000, ctrl} :
		sel_align ? {18'h00000, gci, align_done, meas} :
		sel_ofs ? {28'h0000000, lane_ofs[d_addr[7:2]]} : 32'h00000000;
	wire fill_begin = ctrl[`TSX_FILL_ARM_BIT] & ctrl[`TSX_FILL_GO_BIT] & ~fill_on; // R19
	wire fill_end = fill_on & (fill_idx == `TSX_FILL_LAST);
	wire [15:0] fill_word = {ctrl[`TSX_PAT_LSB +: 2], 14'h0000}; // R19

	// Offset measurement edges in the detected format.
	wire fp_edge = gci ? (frame_sync_pulse & ~fp_h) : (~frame_sync_pulse & fp_h); // R18
	wire fe_edge = gci ? (frame_eval_in & ~fe_h) : (~frame_eval_in & fe_h); // R18
	wire sfe = ctrl[`TSX_SFE_BIT];
	wire ev_go = sfe & ~sfe_q & low_frame; // R16 R17

	assign hreadyout = ~d_rd;
	assign hresp = 1'b0;

	// Bus address phase capture and read data register.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			d_wr <= 1'b0;
			d_rd <= 1'b0;
			d_addr <= 18'h00000;
			hrdata <= 32'h00000000;
		end
		else
		begin
			d_wr <= take & hwrite;
			d_rd <= take & ~hwrite;
			if (take)
				d_addr <= haddr[17:0];
			if (d_rd)
				hrdata <= rd_val;
		end
	end

	// Control register; a bus write wins over the fill completion clear.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl <= `TSX_CTRL_RST;
		else if (d_wr & sel_ctrl)
			ctrl <= hwdata[8:0] & `TSX_CTRL_MASK;
		else if (fill_end)
			ctrl <= ctrl & `TSX_FILL_CLR; // R20
	end

	// Per-lane input offset registers.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			for (int i = 0; i < NL; i++)
				lane_ofs[i] <= 4'h0;
		else if (d_wr & sel_ofs)
			lane_ofs[d_addr[7:2]] <= hwdata[3:0]; // R15
	end

	// Connection memory: bulk fill writes every lane at once, else bus writes.
	always_ff @(posedge hclk)
	begin
		if (fill_on)
			for (int i = 0; i < NL; i++)
				cm[i][fill_idx] <= fill_word; // R19
		else if (d_wr & sel_cm)
			cm[d_addr[15:10]][d_addr[9:2]] <= hwdata[15:0]; // R4
	end

	// Fill sequencer, one channel across all lanes per cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fill_on <= 1'b0;
			fill_idx <= 8'h00;
		end
		else
		begin
			if (fill_begin)
				fill_on <= 1'b1;
			else if (fill_end)
				fill_on <= 1'b0;
			fill_idx <= fill_on ? fill_idx + 8'h01 : 8'h00;
		end
	end

	// Frame pulse tracking, format detection and bit timing.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mclk_q <= 1'b0;
			fp_q <= 1'b1;
			fp_run <= 4'hf;
			fp_armed <= 1'b0;
			gci <= 1'b0;
			phase <= 1'b0;
			bit_cnt <= 11'h000;
			samp_hist <= 15'h0000;
			fs_hist <= 15'h0000;
			wbuf <= 2'h0;
		end
		else
		begin
			mclk_q <= master_clk;
			fp_armed <= (fp_armed | pulse_end) & ~frame_start;
			wbuf <= next_wbuf;
			if (m_edge)
			begin
				fp_q <= frame_sync_pulse;
				samp_hist <= {samp_hist[13:0], samp_ev};
				fs_hist <= {fs_hist[13:0], frame_start};
				if (fp_chg)
					fp_run <= 4'h0;
				else if (fp_run != 4'hf)
					fp_run <= fp_run + 4'h1;
				if (pulse_end)
					gci <= fp_q; // R10
			end
			if (frame_start)
				phase <= 1'b1;
			else if (launch_ev)
				phase <= ~phase; // R12 R14
			if (out_tick)
				bit_cnt <= cur_bit + 11'h001;
		end
	end

	// Per-lane serial input and output paths.
	for (genvar l = 0; l < NL; l++)
	begin : g_lane
		wire [15:0] s_vec = {samp_hist, samp_ev};
		wire [15:0] f_vec = {fs_hist, frame_start};
		wire l_samp = m_edge & s_vec[lane_ofs[l]]; // R15
		wire l_fs = m_edge & f_vec[lane_ofs[l]]; // R15
		wire [15:0] ce = cm[l][out_ch]; // R4
		wire [7:0] src_ch = ce[7:0];
		wire late = {1'b0, out_ch} > ({1'b0, src_ch} + `TSX_VAR_GAP); // R21
		logic [10:0] rcnt;
		logic [7:0] rsr;
		logic [1:0] rbuf;
		logic [7:0] tsr;
		logic hiz;
		assign lane_mode[l] = ce[15:14]; // R6
		assign lane_rb[l] = (lane_mode[l] == tsx_pkg::TSX_MODE_CONST) ? buf_back(next_wbuf, 2'h2) :
			late ? next_wbuf : buf_back(next_wbuf, 2'h1); // R21 R22
		assign lane_next[l] = (lane_mode[l] == tsx_pkg::TSX_MODE_PROC) ? ce[7:0] :
			dm[lane_rb[l]][ce[13:8]][src_ch]; // R5 R23
		assign lane_sr[l] = tsr;
		assign tx_lane[l] = tsr[7];
		assign tx_oe_n[l] = hiz | ~master_en; // R6 R7 R24
		assign rx_wr[l] = l_samp & (rcnt[2:0] == 3'h7);
		assign rx_byte[l] = {rsr[6:0], rx_lane[l]};
		assign rx_wch[l] = rcnt[10:3] & mask;
		assign rx_wbuf[l] = rbuf;
		// Lane shift registers and input channel counter.
		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
			begin
				rcnt <= 11'h000;
				rsr <= 8'h00;
				rbuf <= 2'h0;
				tsr <= 8'h00;
				hiz <= 1'b1;
			end
			else
			begin
				if (l_fs)
				begin
					rcnt <= 11'h000;
					rbuf <= (lane_ofs[l] == 4'h0) ? next_wbuf : wbuf; // R25
				end
				else if (l_samp)
				begin
					rcnt <= rcnt + 11'h001;
					rsr <= rx_byte[l];
				end
				if (out_load)
				begin
					tsr <= lane_next[l]; // R2
					hiz <= lane_mode[l] == tsx_pkg::TSX_MODE_HIZ; // R6
				end
				else if (out_tick)
					tsr <= {tsr[6:0], 1'b0};
			end
		end
	end

	// Data memory writes of completed input bytes into the lane's frame buffer.
	always_ff @(posedge hclk)
	begin
		for (int i = 0; i < NL; i++)
			if (rx_wr[i])
				dm[rx_wbuf[i]][i][rx_wch[i]] <= rx_byte[i]; // R3 R25
	end

	// Frame offset measurement.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ev_state <= tsx_pkg::EV_IDLE;
			ev_frames <= 2'h0;
			meas <= 12'h000;
			align_done <= 1'b0;
			sfe_q <= 1'b0;
			low_frame <= 1'b0;
			fp_h <= 1'b1;
			fe_h <= 1'b1;
		end
		else
		begin
			sfe_q <= sfe;
			fp_h <= frame_sync_pulse;
			fe_h <= frame_eval_in;
			low_frame <= sfe ? 1'b0 : (low_frame | frame_start); // R17
			if (ev_go)
			begin
				ev_state <= tsx_pkg::EV_ARM;
				ev_frames <= 2'h0;
				align_done <= 1'b0;
			end
			else if (ev_state != tsx_pkg::EV_IDLE && frame_start && ev_frames == 2'h1)
			begin
				ev_state <= tsx_pkg::EV_IDLE;
				align_done <= 1'b1; // R16
			end
			else
			begin
				if (frame_start)
					ev_frames <= ev_frames + 2'h1;
				case (ev_state)
					tsx_pkg::EV_ARM:
						if (fp_edge)
						begin
							ev_state <= tsx_pkg::EV_CNT;
							meas <= 12'h000;
						end
					tsx_pkg::EV_CNT:
					begin
						// The master edge that carries the evaluation edge is counted too, so the offset is edge to edge.
						if (m_edge)
							meas <= meas + 12'h001;
						if (fe_edge)
							ev_state <= tsx_pkg::EV_HOLD; // R18
					end
					default:
						ev_state <= ev_state;
				endcase
			end
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence fill_run_s;
		fill_on [*8];
	endsequence
	sequence fill_clear_s;
		!fill_on && ctrl[`TSX_FILL_GO_BIT +: 2] == 2'h0 && ctrl[`TSX_PAT_LSB +: 2] == 2'h0;
	endsequence

	master_hiz_a: assert property (!master_output_drive && !ctrl[`TSX_OSB_BIT] |-> &tx_oe_n) // R7
		else $error("outputs driven while master drive is off");
	chan_hiz_a: assert property (out_load && lane_mode[0] == tsx_pkg::TSX_MODE_HIZ |=> tx_oe_n[0]) // R6
		else $error("float channel still driven");
	proc_byte_a: assert property (out_load && lane_mode[0] == tsx_pkg::TSX_MODE_PROC |=>
		lane_sr[0] == $past(cm[0][out_ch][7:0])) // R5
		else $error("processor byte not loaded");
	fill_steps_a: assert property (fill_begin && !d_wr |=> fill_run_s ##(`TSX_FILL_CYCLES - 8) fill_clear_s) // R19 R20
		else $error("bulk fill did not finish and clear");
	fill_word_a: assert property (fill_on |=> cm[0][$past(fill_idx)] == $past(fill_word)) // R19
		else $error("bulk fill word wrong");
	eval_done_a: assert property ($rose(align_done) |-> $past(frame_start) && $past(ev_frames) == 2'h1) // R16
		else $error("measurement done at wrong frame");
	eval_rearm_a: assert property (sfe && !sfe_q && !low_frame |=> ev_state == $past(ev_state)) // R17
		else $error("measurement restarted without a low frame");
	format_edge_a: assert property (samp_ev |-> (gci ? m_fall : m_rise)) // R11 R13
		else $error("sample on wrong clock edge");
	classify_a: assert property (pulse_end |=> gci == $past(fp_q)) // R10
		else $error("frame format misclassified");
	const_buf_a: assert property (lane_mode[0] == tsx_pkg::TSX_MODE_CONST |-> lane_rb[0] != next_wbuf) // R22 R25
		else $error("constant delay reads the buffer being written");
	slow_bit_a: assert property (!top_rate && boundary && !frame_start |=> !boundary) // R12 R14
		else $error("lower rate boundary too soon");
endmodule
`default_nettype wire

/* tsx_defines.svh */
`ifndef TSX_DEFINES_SVH
`define TSX_DEFINES_SVH
// Lane and memory geometry.
`define TSX_LANES 64
`define TSX_CHANS 256
// Register byte addresses and pages.
`define TSX_CTRL_ADDR 18'h00000
`define TSX_ALIGN_ADDR 18'h00004
`define TSX_OFS_PAGE 10'h001
`define TSX_CM_PAGE 2'h1
// Control register fields.
`define TSX_RATE_LSB 0
`define TSX_OSB_BIT 2
`define TSX_SFE_BIT 3
`define TSX_FILL_GO_BIT 4
`define TSX_FILL_ARM_BIT 5
`define TSX_PAT_LSB 7
`define TSX_CTRL_RST 9'h000
`define TSX_CTRL_MASK 9'h1bf
`define TSX_FILL_CLR 9'h04f
// Alignment register fields.
`define TSX_DONE_BIT 12
`define TSX_GCI_BIT 13
// Timing counts.
`define TSX_PULSE_MAX 4'h8
`define TSX_VAR_GAP 9'h002
`define TSX_FILL_LAST 8'hff
`define TSX_FILL_CYCLES 257
`endif

/* tsx_pkg.sv */
package tsx_pkg;
	// Per-channel output mode selector.
	typedef enum logic [1:0] {TSX_MODE_VAR = 2'h0, TSX_MODE_CONST = 2'h1, TSX_MODE_PROC = 2'h2,
		TSX_MODE_HIZ = 2'h3} tsx_mode_t;
	// Serial rate selector.
	typedef enum logic [1:0] {TSX_RATE_2M = 2'h0, TSX_RATE_4M = 2'h1, TSX_RATE_8M = 2'h2,
		TSX_RATE_16M = 2'h3} tsx_rate_t;
	// Frame offset measurement states.
	typedef enum logic [1:0] {EV_IDLE, EV_ARM, EV_CNT, EV_HOLD} tsx_eval_t;
endpackage

/* tsx_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module tsx_far_end #(parameter int HALF = 4)
(
	// Clock, reset and framing format choice.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic gci,
	// Backplane side.
	output logic master_clk,
	output logic frame_sync_pulse,
	output logic frame_eval_in,
	output logic [63:0] rx_lane
);
	logic [2:0] hc;
	logic [9:0] e;
	logic [7:0] rx_byte;
	logic pulse_on;
	logic eval_lo;
	// Each channel carries its number in the top five bits, so a wrong source shows.
	assign rx_byte = {e[9:5], 3'h5};
	assign pulse_on = (e >= 10'h3fe);
	assign eval_lo = (e >= 10'h004) && (e <= 10'h007);
	// The pulse ends on the falling edge that starts bit 0; both levels invert for the other format.
	assign frame_sync_pulse = gci ? pulse_on : ~pulse_on;
	assign frame_eval_in = gci ? eval_lo : ~eval_lo;
	// Two master clocks per bit; a new bit starts on every second falling edge.
	assign master_clk = e[0];
	assign rx_lane = {64{rx_byte[~e[4:2]]}};
	// Half-period timer and master edge counter, 1024 edges to a frame.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hc <= 3'h0;
			e <= 10'h000;
		end
		else if (hc == 3'(HALF - 1))
		begin
			hc <= 3'h0;
			e <= e + 10'h001;
		end
		else
			hc <= hc + 3'h1;
	end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, master_output_drive, gci;
	logic master_clk, frame_sync_pulse, frame_eval_in, mc_q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [63:0] rx_lane, tx_lane, tx_oe_n;
	logic [15:0] sh [0:2];
	int n_errors;
	int total_checks;
	// The only slave on the bus drives the bus ready.
	assign hready = hreadyout;
	tsx_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.master_clk(master_clk), .frame_sync_pulse(frame_sync_pulse), .frame_eval_in(frame_eval_in),
		.master_output_drive(master_output_drive), .rx_lane(rx_lane), .tx_lane(tx_lane), .tx_oe_n(tx_oe_n));
	tsx_far_end far (.hclk(hclk), .hresetn(hresetn), .gci(gci), .master_clk(master_clk),
		.frame_sync_pulse(frame_sync_pulse), .frame_eval_in(frame_eval_in), .rx_lane(rx_lane));
	// The 40 MHz bus clock.
	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// Every master rising edge samples each bit cell twice on lanes 0 to 2.
	always @(posedge hclk)
	begin
		mc_q <= master_clk;
		if (master_clk && !mc_q)
			for (int i = 0; i < 3; i++)
				sh[i] <= {sh[i][14:0], tx_lane[i]};
	end
	// A byte as it looks when each bit is seen twice.
	function automatic logic [15:0] dbl(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			dbl[2*i +: 2] = {2{b[i]}};
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task chk_seen(input string n, input logic e, input logic g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s exp %b got %b", n, e, g);
		end
	endtask
	// Pin vectors are looked at mid-cycle, once the edge's updates have landed.
	task pins(input string n, input logic [63:0] e);
		@(negedge hclk);
		total_checks++;
		if (tx_oe_n !== e)
		begin
			n_errors++;
			$display("mismatch %s exp %h got %h", n, e, tx_oe_n);
		end
		@(posedge hclk);
	endtask
	// One bus phase: hold until hready is high at a rising edge, take hrdata there.
	task phase();
		logic r;
		int n;
		n = 0;
		do
		begin
			@(negedge hclk);
			r = hreadyout;
			rd = hrdata;
			@(posedge hclk);
			n++;
		end
		while (r !== 1'b1 && n < 40);
		if (r !== 1'b1)
			chk_seen("bus_ready", 1'b1, r);
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		phase();
		htrans <= 2'h0;
		hwdata <= wd;
		phase();
	endtask
	// Waits up to about three frames for a byte to pass on a lane.
	task look(input string n, input int l, input logic [7:0] b);
		logic f;
		f = 1'b0;
		for (int i = 0; i < 12000 && !f; i++)
		begin
			@(negedge hclk);
			f = (sh[l] === dbl(b));
		end
		@(posedge hclk);
		chk_seen(n, 1'b1, f);
	endtask
	task t_regs;
		bus(0, 32'h0, 32'h0);
		chk("ctrl_reset", 32'h0, rd);
		chk("bus_resp", 32'h0, {31'h0, hresp});
		bus(1, 32'h0, 32'h1c3);
		bus(0, 32'h0, 32'h0);
		chk("ctrl_rate", 32'h183, rd);
		bus(1, 32'h0, 32'h0);
		bus(1, 32'h10c, 32'h1f);
		bus(0, 32'h10c, 32'h0);
		chk("lane_offset", 32'hf, rd);
		bus(1, 32'h100, 32'h0);
		bus(0, 32'h8000, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("test regs done");
	endtask
	// Bulk fill: entries take the pattern, control fill bits clear themselves.
	task t_fill(input logic [1:0] p);
		bus(1, 32'h0, {23'h0, p, 7'h30});
		repeat (260) @(posedge hclk);
		bus(0, 32'h0, 32'h0);
		chk("fill_clear", 32'h0, rd);
		bus(0, 32'h11f20, 32'h0);
		chk("fill_entry", {16'h0, p, 14'h0}, rd);
		$display("test fill done");
	endtask
	task t_oe;
		t_fill(2'h3);
		master_output_drive <= 1'b1;
		repeat (300) @(posedge hclk);
		pins("oe_chan_float", {64{1'b1}});
		t_fill(2'h2);
		repeat (300) @(posedge hclk);
		pins("oe_all_drive", 64'h0);
		master_output_drive <= 1'b0;
		pins("oe_master_off", {64{1'b1}});
		bus(1, 32'h0, 32'h4);
		pins("oe_standby", 64'h0);
		bus(1, 32'h0, 32'h0);
		master_output_drive <= 1'b1;
		pins("oe_drive_pin", 64'h0);
		$display("test oe done");
	endtask
	// Processor byte, variable and constant paths from lane 0.
	task t_path;
		bus(1, 32'h10014, 32'h80a5);
		bus(0, 32'h10014, 32'h0);
		chk("entry_back", 32'h80a5, rd);
		bus(1, 32'h10428, 32'h0003);
		bus(1, 32'h10810, 32'h4006);
		look("proc_byte", 0, 8'ha5);
		look("var_path", 1, 8'h1d);
		look("const_path", 2, 8'h35);
		bus(1, 32'h10014, 32'h803c);
		look("proc_change", 0, 8'h3c);
		$display("test path done");
	endtask
	task t_eval;
		int n;
		bus(1, 32'h0, 32'h8);
		bus(0, 32'h4, 32'h0);
		chk("eval_busy", 32'h0, rd & 32'h1000);
		for (n = 0; n < 80 && rd[12] !== 1'b1; n++)
		begin
			repeat (200) @(posedge hclk);
			bus(0, 32'h4, 32'h0);
		end
		chk("eval_result", 32'h1006, rd & 32'h3fff);
		chk_seen("eval_wait", 1'b1, n > 15);
		bus(1, 32'h0, 32'h0);
		$display("test eval done");
	endtask
	task t_gci;
		gci <= 1'b1;
		repeat (12300) @(posedge hclk);
		bus(0, 32'h4, 32'h0);
		chk("gci_flag", 32'h2000, rd & 32'h2000);
		$display("test gci done");
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Reset, then the scenarios in order.
	initial
	begin
		n_errors = 0;
		total_checks = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		master_output_drive = 1'b0;
		gci = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_oe();
		t_path();
		t_eval();
		t_gci();
		test_done();
	end
	// A hang is cut short well after the expected run length.
	initial
	begin
		#2000000;
		n_errors++;
		$display("mismatch watchdog exp end got hang");
		test_done();
	end
endmodule
`default_nettype wire
